// [cfef_pkg.sv]
package cfef_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned CHG_STATE_W = 3;
  localparam int unsigned ICO_STATE_W = 2;
  localparam int unsigned BUS_STATE_W = 4;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  // Printed offsets are not word aligned, so the byte address is 4 x index
  localparam logic [7:0] IDX_FAULT = 8'h21;
  localparam logic [7:0] IDX_FLAG0 = 8'h22;
  localparam logic [7:0] IDX_FLAG1 = 8'h23;
  localparam logic [ADDR_W-1:0] ADDR_FAULT = ADDR_W'(4 * IDX_FAULT);
  localparam logic [ADDR_W-1:0] ADDR_FLAG0 = ADDR_W'(4 * IDX_FLAG0);
  localparam logic [ADDR_W-1:0] ADDR_FLAG1 = ADDR_W'(4 * IDX_FLAG1);

  // ----------------------------------------------------------------
  // Field positions, masks, reset values
  // ----------------------------------------------------------------
  localparam int unsigned FAULT_SHORT_BIT = 7;
  localparam int unsigned FAULT_OVP_BIT = 6;
  localparam int unsigned FAULT_TSHUT_BIT = 2;
  localparam int unsigned F0_IIN_BIT = 7;
  localparam int unsigned F0_VIN_BIT = 6;
  localparam int unsigned F0_WD_BIT = 5;
  localparam int unsigned F0_WEAK_BIT = 4;
  localparam int unsigned F0_PG_BIT = 3;
  localparam int unsigned F0_IN2_BIT = 2;
  localparam int unsigned F0_IN1_BIT = 1;
  localparam int unsigned F0_BUS_BIT = 0;
  localparam int unsigned F1_CHG_BIT = 7;
  localparam int unsigned F1_ICO_BIT = 6;
  localparam int unsigned F1_BUS_BIT = 4;
  localparam int unsigned F1_THERMAL_REGULATION_BIT = 2;
  localparam int unsigned F1_BAT_BIT = 1;
  localparam int unsigned F1_PORT_BIT = 0;
  localparam logic [REG_W-1:0] FAULT_MASK = 8'hC4;
  localparam logic [REG_W-1:0] FLAG0_MASK = 8'hFF;
  localparam logic [REG_W-1:0] FLAG1_MASK = 8'hD7;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_FAULT = 2'b01,
    SEL_FLAG0 = 2'b10,
    SEL_FLAG1 = 2'b11
  } cfef_sel_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W/8-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } cfef_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } cfef_axi_rsp_t;

  typedef struct packed {
    logic input_current_regulation;
    logic input_voltage_regulation;
    logic watchdog_expired;
    logic weak_source_status;
    logic power_good_status;
    logic input2_present;
    logic input1_present;
    logic bus_input_present;
    logic [CHG_STATE_W-1:0] charge_state;
    logic [ICO_STATE_W-1:0] input_current_optimizer;
    logic [BUS_STATE_W-1:0] bus_input_state;
    logic thermal_regulation;
    logic battery_present;
    logic port_detection_status;
  } cfef_sources_t;

  typedef struct packed {
    logic system_short_status;
    logic system_overvoltage_status;
    logic thermal_shutdown_status;
  } cfef_faults_t;

endpackage

// [cfef_edge_detect.sv]
`timescale 1ns/1ps
module cfef_edge_detect #(
  parameter int unsigned W = 1
) (
  input wire logic clk, // Device clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [W-1:0] sample, // Live source levels
  output logic [W-1:0] rise, // Bit went 0 to 1 this cycle
  output logic [W-1:0] change // Bit toggled this cycle
);

  typedef struct packed {
    logic armed;
    logic [W-1:0] prev;
  } cfef_edge_state_t;

  cfef_edge_state_t state_q;
  cfef_edge_state_t state_d;

  // Not armed in the first cycle after reset, so levels already high at
  // release do not report a false edge.
  always_comb begin
    state_d = state_q;
    state_d.armed = 1'b1;
    state_d.prev = sample;
    rise = state_q.armed ? (sample & ~state_q.prev) : '0;
    change = state_q.armed ? (sample ^ state_q.prev) : '0;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// [cfef_flag_reg.sv]
`timescale 1ns/1ps
module cfef_flag_reg #(
  parameter logic [cfef_pkg::REG_W-1:0] VALID_MASK = 8'hFF
) (
  input wire logic clk, // Device clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [cfef_pkg::REG_W-1:0] set, // Event pulses
  input wire logic clear, // Read-clear strobe
  output logic [cfef_pkg::REG_W-1:0] flags // Sticky flags
);

  typedef struct packed {
    logic [cfef_pkg::REG_W-1:0] flags;
  } cfef_flag_state_t;

  cfef_flag_state_t state_q;
  cfef_flag_state_t state_d;

  // A set in the clearing cycle survives; reserved bits never hold a one.
  always_comb begin
    state_d = state_q;
    state_d.flags = ((state_q.flags & ~{cfef_pkg::REG_W{clear}}) | set)
      & VALID_MASK;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q.flags <= cfef_pkg::REG_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags = state_q.flags;

endmodule

// [cfef_charger_flags.sv]
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cfef_charger_flags (
  input wire logic clk, // Device clock, 125 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire cfef_pkg::cfef_axi_req_t axi_req, // AXI4-Lite master side
  output cfef_pkg::cfef_axi_rsp_t axi_rsp, // AXI4-Lite slave side
  input wire cfef_pkg::cfef_faults_t faults, // Live protection states
  input wire cfef_pkg::cfef_sources_t sources // Live event sources
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } cfef_rd_state_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_HAVE_ADDR = 2'b01,
    WR_HAVE_DATA = 2'b10,
    WR_RESP = 2'b11
  } cfef_wr_state_t;

  typedef struct packed {
    cfef_rd_state_t rd_state;
    cfef_wr_state_t wr_state;
    logic wr_addr_ok;
    logic [cfef_pkg::REG_W-1:0] fault;
    cfef_pkg::cfef_axi_rsp_t rsp;
  } cfef_state_t;

  cfef_state_t state_q;
  cfef_state_t state_d;

  cfef_pkg::cfef_sources_t rise_s;
  cfef_pkg::cfef_sources_t change_s;
  logic [$bits(cfef_pkg::cfef_sources_t)-1:0] rise_v;
  logic [$bits(cfef_pkg::cfef_sources_t)-1:0] change_v;
  logic [cfef_pkg::REG_W-1:0] set0;
  logic [cfef_pkg::REG_W-1:0] set1;
  logic [cfef_pkg::REG_W-1:0] flags0;
  logic [cfef_pkg::REG_W-1:0] flags1;
  logic [cfef_pkg::REG_W-1:0] fault_d;
  logic clear0;
  logic clear1;
  logic rd_take;
  cfef_pkg::cfef_sel_t rd_sel;
  cfef_pkg::cfef_sel_t wr_sel;
  logic aw_take;
  logic w_take;
  logic bus_quiet;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Shared by the read and the write address decode
  function automatic cfef_pkg::cfef_sel_t decode(
    input logic [cfef_pkg::ADDR_W-1:0] addr
  );
    cfef_pkg::cfef_sel_t sel;
    if (addr == cfef_pkg::ADDR_FAULT) begin
      sel = cfef_pkg::SEL_FAULT;
    end else if (addr == cfef_pkg::ADDR_FLAG0) begin
      sel = cfef_pkg::SEL_FLAG0;
    end else if (addr == cfef_pkg::ADDR_FLAG1) begin
      sel = cfef_pkg::SEL_FLAG1;
    end else begin
      sel = cfef_pkg::SEL_NONE;
    end
    return sel;
  endfunction

  // Narrow register placed in the low byte, upper bits zero
  function automatic logic [cfef_pkg::DATA_W-1:0] widen(
    input logic [cfef_pkg::REG_W-1:0] value
  );
    return {{(cfef_pkg::DATA_W - cfef_pkg::REG_W){1'b0}}, value};
  endfunction

  // ----------------------------------------------------------------
  // Response helpers
  // ----------------------------------------------------------------
  // One answer code per decoded address
  function automatic logic [1:0] resp_for(
    input cfef_pkg::cfef_sel_t sel
  );
    logic [1:0] code;
    if (sel == cfef_pkg::SEL_NONE) begin
      code = cfef_pkg::RESP_DECERR;
    end else begin
      code = cfef_pkg::RESP_OKAY;
    end
    return code;
  endfunction

  // Register picked by a read; an unmapped address reads as zero
  function automatic logic [cfef_pkg::DATA_W-1:0] read_word(
    input cfef_pkg::cfef_sel_t sel,
    input logic [cfef_pkg::REG_W-1:0] fault,
    input logic [cfef_pkg::REG_W-1:0] f0,
    input logic [cfef_pkg::REG_W-1:0] f1
  );
    logic [cfef_pkg::DATA_W-1:0] word;
    if (sel == cfef_pkg::SEL_FAULT) begin
      word = widen(fault);
    end else if (sel == cfef_pkg::SEL_FLAG0) begin
      word = widen(f0);
    end else if (sel == cfef_pkg::SEL_FLAG1) begin
      word = widen(f1);
    end else begin
      word = '0;
    end
    return word;
  endfunction

  // ----------------------------------------------------------------
  // Edge detection of event sources
  // ----------------------------------------------------------------
  cfef_edge_detect #(
    .W($bits(cfef_pkg::cfef_sources_t))
  ) u_edges (
    .clk(clk),
    .reset(reset),
    .sample(sources),
    .rise(rise_v),
    .change(change_v)
  );

  assign rise_s = rise_v;
  assign change_s = change_v;

  always_comb begin
    set0 = '0;
    set1 = '0;
    set0[cfef_pkg::F0_IIN_BIT] = rise_s.input_current_regulation;
    set0[cfef_pkg::F0_VIN_BIT] = rise_s.input_voltage_regulation;
    set0[cfef_pkg::F0_WD_BIT] = rise_s.watchdog_expired;
    set0[cfef_pkg::F0_WEAK_BIT] = rise_s.weak_source_status;
    set0[cfef_pkg::F0_PG_BIT] = change_s.power_good_status;
    set0[cfef_pkg::F0_IN2_BIT] = change_s.input2_present;
    set0[cfef_pkg::F0_IN1_BIT] = change_s.input1_present;
    set0[cfef_pkg::F0_BUS_BIT] = change_s.bus_input_present;
    set1[cfef_pkg::F1_CHG_BIT] = |change_s.charge_state;
    set1[cfef_pkg::F1_ICO_BIT] =
      |change_s.input_current_optimizer;
    set1[cfef_pkg::F1_BUS_BIT] = |change_s.bus_input_state;
    set1[cfef_pkg::F1_THERMAL_REGULATION_BIT] = rise_s.thermal_regulation;
    set1[cfef_pkg::F1_BAT_BIT] = change_s.battery_present;
    set1[cfef_pkg::F1_PORT_BIT] =
      change_s.port_detection_status;
  end

  // ----------------------------------------------------------------
  // Sticky flag registers
  // ----------------------------------------------------------------
  cfef_flag_reg #(
    .VALID_MASK(cfef_pkg::FLAG0_MASK)
  ) u_flags0 (
    .clk(clk),
    .reset(reset),
    .set(set0),
    .clear(clear0),
    .flags(flags0)
  );

  cfef_flag_reg #(
    .VALID_MASK(cfef_pkg::FLAG1_MASK)
  ) u_flags1 (
    .clk(clk),
    .reset(reset),
    .set(set1),
    .clear(clear1),
    .flags(flags1)
  );

  // ----------------------------------------------------------------
  // Live fault status
  // ----------------------------------------------------------------
  // Sampled each cycle, so a read shows the state one cycle old.
  always_comb begin
    fault_d = cfef_pkg::REG_RESET;
    fault_d[cfef_pkg::FAULT_SHORT_BIT] =
      faults.system_short_status;
    fault_d[cfef_pkg::FAULT_OVP_BIT] =
      faults.system_overvoltage_status;
    fault_d[cfef_pkg::FAULT_TSHUT_BIT] =
      faults.thermal_shutdown_status;
    fault_d = fault_d & cfef_pkg::FAULT_MASK;
  end

  // ----------------------------------------------------------------
  // Bus take strobes
  // ----------------------------------------------------------------
  // Each channel is taken only while its own ready stands high, so a
  // valid raised in the quiet cycle after reset simply waits.
  assign rd_take = axi_req.arvalid && state_q.rsp.arready;
  assign aw_take = axi_req.awvalid && state_q.rsp.awready;
  assign w_take = axi_req.wvalid && state_q.rsp.wready;
  assign rd_sel = decode(axi_req.araddr);
  assign wr_sel = decode(axi_req.awaddr);

  // Readies come up one cycle after reset release, so every bus output
  // resets to a constant and no request is taken in that first cycle.
  assign bus_quiet = (state_q.rsp == '0) && (state_q.rd_state == RD_IDLE)
    && (state_q.wr_state == WR_IDLE);

  // ----------------------------------------------------------------
  // Read-clear strobes
  // ----------------------------------------------------------------
  // The flag value is captured into rdata in the same edge that clears it,
  // so nothing read is lost and no event in between is dropped.
  assign clear0 = rd_take && (rd_sel == cfef_pkg::SEL_FLAG0);
  assign clear1 = rd_take && (rd_sel == cfef_pkg::SEL_FLAG1);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.fault = fault_d;

    // Read channel: one read under way at a time
    case (state_q.rd_state)
      RD_IDLE: begin
        if (rd_take) begin
          state_d.rsp.arready = 1'b0;
          state_d.rsp.rvalid = 1'b1;
          state_d.rd_state = RD_RESP;
          state_d.rsp.rdata = read_word(rd_sel, state_q.fault, flags0,
            flags1);
          state_d.rsp.rresp = resp_for(rd_sel);
        end
      end
      RD_RESP: begin
        if (axi_req.rready) begin
          state_d.rsp.rvalid = 1'b0;
          state_d.rsp.arready = 1'b1;
          state_d.rd_state = RD_IDLE;
        end
      end
      default: begin
        state_d.rd_state = RD_IDLE;
      end
    endcase

    // Write channel: address and data in either order; data are dropped
    // because every register here is read-only.
    case (state_q.wr_state)
      WR_IDLE: begin
        if (aw_take && w_take) begin
          state_d.rsp.awready = 1'b0;
          state_d.rsp.wready = 1'b0;
          state_d.rsp.bvalid = 1'b1;
          state_d.rsp.bresp = (wr_sel == cfef_pkg::SEL_NONE) ?
            cfef_pkg::RESP_DECERR : cfef_pkg::RESP_OKAY;
          state_d.wr_state = WR_RESP;
        end else if (aw_take) begin
          state_d.rsp.awready = 1'b0;
          state_d.wr_addr_ok = (wr_sel != cfef_pkg::SEL_NONE);
          state_d.wr_state = WR_HAVE_ADDR;
        end else if (w_take) begin
          state_d.rsp.wready = 1'b0;
          state_d.wr_state = WR_HAVE_DATA;
        end
      end
      WR_HAVE_ADDR: begin
        if (w_take) begin
          state_d.rsp.wready = 1'b0;
          state_d.rsp.bvalid = 1'b1;
          state_d.rsp.bresp = state_q.wr_addr_ok ?
            cfef_pkg::RESP_OKAY : cfef_pkg::RESP_DECERR;
          state_d.wr_state = WR_RESP;
        end
      end
      WR_HAVE_DATA: begin
        if (aw_take) begin
          state_d.rsp.awready = 1'b0;
          state_d.rsp.bvalid = 1'b1;
          state_d.rsp.bresp = (wr_sel == cfef_pkg::SEL_NONE) ?
            cfef_pkg::RESP_DECERR : cfef_pkg::RESP_OKAY;
          state_d.wr_state = WR_RESP;
        end
      end
      WR_RESP: begin
        if (axi_req.bready) begin
          state_d.rsp.bvalid = 1'b0;
          state_d.rsp.awready = 1'b1;
          state_d.rsp.wready = 1'b1;
          state_d.wr_state = WR_IDLE;
        end
      end
      default: begin
        state_d.wr_state = WR_IDLE;
      end
    endcase

    // Open all three address and data channels after the quiet cycle
    if (bus_quiet) begin
      state_d.rsp.arready = 1'b1;
      state_d.rsp.awready = 1'b1;
      state_d.rsp.wready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q.rd_state <= RD_IDLE;
      state_q.wr_state <= WR_IDLE;
      state_q.wr_addr_ok <= 1'b0;
      state_q.fault <= cfef_pkg::REG_RESET;
      state_q.rsp <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  assign axi_rsp = state_q.rsp;

endmodule

// [cfef_charger_flags_props.sv]
`timescale 1ns/1ps
module cfef_charger_flags_props (
  input wire logic clk, // Device clock
  input wire logic reset, // Synchronous reset, active high
  input wire cfef_pkg::cfef_axi_req_t axi_req, // Bus requests
  input wire cfef_pkg::cfef_axi_rsp_t axi_rsp, // Bus responses
  input wire cfef_pkg::cfef_faults_t faults, // Live protection states
  input wire cfef_pkg::cfef_sources_t sources // Live event sources
);
  // ----------------------------------------------------------------
  // Reference flag state
  // ----------------------------------------------------------------
  logic [19:0] s;
  logic [19:0] p;
  logic [7:0] ev0;
  logic [7:0] ev1;
  logic [7:0] flt;
  logic [7:0] exp0_q;
  logic [7:0] exp1_q;
  logic [19:0] prev_q;
  logic ar_take;
  logic take0;
  logic take1;
  logic take_f;
  logic rd_map;
  logic wr_map;

  assign s = sources;
  assign p = prev_q;
  assign ar_take = axi_req.arvalid && axi_rsp.arready;
  assign take0 = ar_take && axi_req.araddr == cfef_pkg::ADDR_FLAG0;
  assign take1 = ar_take && axi_req.araddr == cfef_pkg::ADDR_FLAG1;
  assign take_f = ar_take && axi_req.araddr == cfef_pkg::ADDR_FAULT;
  assign rd_map = take0 || take1 || take_f;
  assign wr_map = axi_req.awaddr inside {cfef_pkg::ADDR_FAULT,
    cfef_pkg::ADDR_FLAG0, cfef_pkg::ADDR_FLAG1};
  assign flt = {faults.system_short_status,
    faults.system_overvoltage_status, 3'b000,
    faults.thermal_shutdown_status, 2'b00};
  // Upper four source bits are rise-only, lower four any change
  assign ev0 = {s[19:16] & ~p[19:16], s[15:12] ^ p[15:12]};
  assign ev1 = {|(s[11:9] ^ p[11:9]), |(s[8:7] ^ p[8:7]), 1'b0,
    |(s[6:3] ^ p[6:3]), 1'b0, s[2] & ~p[2], s[1:0] ^ p[1:0]};

  // Loading the history in reset means levels held over release
  // make no event, as the detectors are unarmed then
  always_ff @(posedge clk) begin
    prev_q <= sources;
    if (reset) begin
      exp0_q <= 8'h00;
      exp1_q <= 8'h00;
    end else begin
      exp0_q <= (exp0_q & ~{8{take0}}) | ev0;
      exp1_q <= (exp1_q & ~{8{take1}}) | ev1;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_RST_QUIET:
    assert property ($fell(reset) |-> !axi_rsp.arready && !axi_rsp.rvalid)
    else $error("bus busy right after reset");
  AST_FAULT_READ:
    assert property (take_f |=> axi_rsp.rdata == {24'h0, $past(flt, 2)})
    else $error("fault status read mismatch");
  AST_FLAG0_RISE:
    assert property (take0 |=> axi_rsp.rdata[7:4] == $past(exp0_q[7:4]))
    else $error("rise flags mismatch");
  AST_FLAG0_CHG:
    assert property (take0 |=> axi_rsp.rdata[7:0] == $past(exp0_q))
    else $error("flags0 read mismatch");
  AST_FLAG1_READ:
    assert property (take1 |=> axi_rsp.rdata == {24'h0, $past(exp1_q)})
    else $error("flags1 read mismatch");
  AST_RVALID_NEXT:
    assert property (ar_take |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read answer not one cycle after take");
  AST_RDATA_HOLD:
    assert property (axi_rsp.rvalid && !axi_req.rready |=>
      axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read answer dropped before rready");
  AST_READ_DECERR:
    assert property (ar_take && !rd_map |=>
      axi_rsp.rresp == cfef_pkg::RESP_DECERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_WRITE_RESP:
    assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
      && axi_rsp.wready |=> axi_rsp.bvalid && axi_rsp.bresp ==
      ($past(wr_map) ? cfef_pkg::RESP_OKAY : cfef_pkg::RESP_DECERR))
    else $error("write response mismatch");

  COV_FLAG0: cover property (take0 ##1 axi_rsp.rdata != 32'h0);
  COV_FAULT: cover property (take_f ##1 axi_rsp.rdata != 32'h0);
  COV_WR_ERR: cover property (axi_rsp.bvalid && axi_rsp.bresp == 2'h3);
endmodule

bind cfef_charger_flags cfef_charger_flags_props u_props (
  .clk(clk),
  .reset(reset),
  .axi_req(axi_req),
  .axi_rsp(axi_rsp),
  .faults(faults),
  .sources(sources)
);

// [test_charger_fault_and_event_flags.sv]
`timescale 1ns/1ps
module test_charger_fault_and_event_flags;
  logic clk;
  logic reset;
  cfef_pkg::cfef_axi_req_t req;
  cfef_pkg::cfef_axi_rsp_t rsp;
  cfef_pkg::cfef_faults_t faults;
  cfef_pkg::cfef_sources_t sources;
  int err_count;
  int check_count;
  int cyc;
  logic [31:0] d;
  logic [1:0] r;

  cfef_charger_flags u_dut (
    .clk(clk), // Device clock
    .reset(reset), // Synchronous reset
    .axi_req(req), // Bus requests
    .axi_rsp(rsp), // Bus responses
    .faults(faults), // Protection states
    .sources(sources) // Event sources
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task tally_and_finish;
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Whole run needs a few hundred cycles at most
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task axi_read(input logic [7:0] a, output logic [31:0] dq,
                output logic [1:0] rq);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    while (rsp.rvalid !== 1'b1) @(posedge clk);
    dq = rsp.rdata;
    rq = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e,
              input logic [1:0] re);
    axi_read(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, re});
  endtask

  // Address and data go out together; each is dropped once taken
  task wr_chk(input logic [7:0] a, input logic [1:0] re);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= 32'hFFFFFFFF;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && rsp.awready === 1'b1) begin
        aw_done = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_done && rsp.wready === 1'b1) begin
        w_done = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    check({30'h0, rsp.bresp}, {30'h0, re});
    req.bready <= 1'b0;
  endtask

  // Raise a source, read set then cleared, drop it, read again
  task flag_case(input logic [19:0] m, input logic [7:0] a,
                 input logic [7:0] e, input logic rise_only);
    @(posedge clk);
    sources <= cfef_pkg::cfef_sources_t'(m);
    repeat (3) @(posedge clk);
    rd_chk(a, {24'h0, e}, cfef_pkg::RESP_OKAY);
    rd_chk(a, 32'h0, cfef_pkg::RESP_OKAY);
    sources <= '0;
    repeat (3) @(posedge clk);
    rd_chk(a, rise_only ? 32'h0 : {24'h0, e}, cfef_pkg::RESP_OKAY);
  endtask

  task f0(input int i);
    flag_case(20'h1000 << i, cfef_pkg::ADDR_FLAG0, 8'h01 << i, i >= 4);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] fexp [3];
    fexp = '{8'h04, 8'h40, 8'h80};
    req = '0;
    faults = '0;
    sources = '0;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd_chk(cfef_pkg::ADDR_FAULT, 32'h0, cfef_pkg::RESP_OKAY);
    rd_chk(cfef_pkg::ADDR_FLAG0, 32'h0, cfef_pkg::RESP_OKAY);
    rd_chk(cfef_pkg::ADDR_FLAG1, 32'h0, cfef_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      faults <= (i == 3) ? 3'h7 : 3'(1 << i);
      repeat (2) @(posedge clk);
      rd_chk(cfef_pkg::ADDR_FAULT, (i == 3) ? 32'hC4 : 32'(fexp[i]),
        cfef_pkg::RESP_OKAY);
    end
    faults <= '0;
    for (int i = 4; i < 8; i++) f0(i);
    for (int i = 0; i < 4; i++) f0(i);
    flag_case(20'h00A00, cfef_pkg::ADDR_FLAG1, 8'h80, 1'b0);
    flag_case(20'h00100, cfef_pkg::ADDR_FLAG1, 8'h40, 1'b0);
    flag_case(20'h00048, cfef_pkg::ADDR_FLAG1, 8'h10, 1'b0);
    flag_case(20'h00004, cfef_pkg::ADDR_FLAG1, 8'h04, 1'b1);
    flag_case(20'h00002, cfef_pkg::ADDR_FLAG1, 8'h02, 1'b0);
    flag_case(20'h00001, cfef_pkg::ADDR_FLAG1, 8'h01, 1'b0);
    // Event lands on the very edge that takes the read
    fork
      axi_read(cfef_pkg::ADDR_FLAG0, d, r);
      begin
        @(posedge clk);
        sources <= cfef_pkg::cfef_sources_t'(20'h01000);
      end
    join
    check(d, 32'h0);
    rd_chk(cfef_pkg::ADDR_FLAG0, 32'h01, cfef_pkg::RESP_OKAY);
    wr_chk(cfef_pkg::ADDR_FAULT, cfef_pkg::RESP_OKAY);
    wr_chk(cfef_pkg::ADDR_FLAG0, cfef_pkg::RESP_OKAY);
    wr_chk(cfef_pkg::ADDR_FLAG1, cfef_pkg::RESP_OKAY);
    wr_chk(8'h80, cfef_pkg::RESP_DECERR);
    rd_chk(cfef_pkg::ADDR_FLAG0, 32'h0, cfef_pkg::RESP_OKAY);
    rd_chk(cfef_pkg::ADDR_FLAG1, 32'h0, cfef_pkg::RESP_OKAY);
    rd_chk(8'h80, 32'h0, cfef_pkg::RESP_DECERR);
    // Pending flags and live sources across a mid-run reset
    @(posedge clk);
    sources <= cfef_pkg::cfef_sources_t'(20'hFFFFF);
    repeat (3) @(posedge clk);
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd_chk(cfef_pkg::ADDR_FLAG0, 32'h0, cfef_pkg::RESP_OKAY);
    rd_chk(cfef_pkg::ADDR_FLAG1, 32'h0, cfef_pkg::RESP_OKAY);
    tally_and_finish();
  end
endmodule
